// ---- logic/bzcg_config_bank.v ----
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "bzcg_defines.vh"

// Notes on behaviour
// - monitor disabled: no compliance watching, no new monitor events; a status bit already set and its interrupt stay until cleared.
// - monitor enabled with channel and generators active: watch compliance, flag events.
// - magnitude 000 off and floating; 001-101 give 8..64 uA; 111 gives 96 uA.
// - frequency code 0010 or above: phase is four-bit code times 11.25 degrees.
// - frequency code 0001: phase is upper three bits times 22.50 degrees.
// - frequency code 0000: phase is upper two bits times 45.00 degrees.
// - unsupported low-pass at halved rate maps to the 4 Hz default.
// - stored low-pass value kept; readback shows the effective internal value.
module bzcg_config_bank (
  input wire clk,
  input wire srst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire channel_active,
  input wire compliance_fault,
  output reg drive_enable,
  output reg [6:0] drive_current_ua,
  output reg drive_out_positive_oe,
  output reg drive_out_negative_oe,
  output reg [15:0] phase_offset_centideg,
  output reg [1:0] effective_lowpass_code,
  output reg monitor_active,
  output wire irq
);

  // stored registers
  reg [23:0] config_reg;
  reg [31:0] gen_reg;
  reg [31:0] status_reg;
  reg [31:0] mask_reg;
  reg [31:0] status_next;

  // write channel capture
  reg [7:0] wr_addr_reg;
  reg wr_addr_full_reg;
  reg [31:0] wr_data_reg;
  reg [3:0] wr_strb_reg;
  reg wr_data_full_reg;

  // compliance edge tracking
  reg fault_seen_reg;

  // decoded views
  wire [1:0] lpf_stored;
  wire [1:0] lpf_effective;
  wire [23:0] config_view;
  wire [6:0] dec_ua;
  wire dec_on;
  wire [15:0] dec_phase;
  wire watch;
  wire event_pulse;
  wire wr_fire;
  wire rd_fire;
  wire [31:0] config_merged;

  // byte lane merge of a write into a stored word
  function [31:0] bzcg_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer i;
    begin
      bzcg_merge = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          bzcg_merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // low-pass remap: highest code only allowed at the full rate
  function [1:0] bzcg_lpf_map;
    input [1:0] code;
    input half_rate;
    begin
      if (half_rate && (code == `BZCG_LPF_HIGHEST)) begin
        bzcg_lpf_map = `BZCG_LPF_DEFAULT;
      end else begin
        bzcg_lpf_map = code;
      end
    end
  endfunction

  // config write merged as a full word, upper byte dropped on store
  assign config_merged = bzcg_merge({8'h00, config_reg}, wr_data_reg, wr_strb_reg);

  assign lpf_stored = config_reg[`BZCG_LPF_MSB:`BZCG_LPF_LSB];
  assign lpf_effective = bzcg_lpf_map(lpf_stored, gen_reg[`BZCG_GEN_RATE_BIT]);

  // readback replaces the low-pass field with the value in use
  assign config_view = {config_reg[23:14], lpf_effective, config_reg[13'd11:0]};

  // field decode shared with the drive logic
  bzcg_drive_decode u_decode (
    .magnitude_code(config_reg[`BZCG_MAG_MSB:`BZCG_MAG_LSB]),
    .frequency_code(config_reg[`BZCG_FREQ_MSB:`BZCG_FREQ_LSB]),
    .phase_code(config_reg[`BZCG_PHASE_MSB:`BZCG_PHASE_LSB]),
    .drive_ua(dec_ua),
    .drive_on(dec_on),
    .phase_centideg(dec_phase)
  );

  // monitor runs only with enable, channel and generators all on
  assign watch = config_reg[`BZCG_MON_BIT] & gen_reg[`BZCG_GEN_EN_BIT]
    & channel_active & dec_on;
  assign event_pulse = watch & compliance_fault & ~fault_seen_reg;

  // handshake outputs
  assign s_axi_awready = ~wr_addr_full_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wr_data_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = wr_addr_full_reg & wr_data_full_reg & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & ~s_axi_rvalid;

  // interrupt is high while an unmasked status bit is set
  assign irq = |(status_reg & mask_reg);

  // status next value: event set wins over write-one-to-clear
  always @* begin
    status_next = status_reg;
    if (wr_fire && (wr_addr_reg == `BZCG_ADDR_STATUS)) begin
      status_next = status_reg & ~bzcg_merge(32'h00000000, wr_data_reg, wr_strb_reg);
    end
    if (event_pulse) begin
      status_next[0] = 1'b1;
    end
    if (!watch) begin
      status_next[0] = status_next[0] & ~event_pulse;
    end
    status_next[31:1] = 31'h00000000;
  end

  // write path: capture address and data in either order, then commit
  always @(posedge clk) begin
    if (srst) begin
      wr_addr_reg <= 8'h00;
      wr_addr_full_reg <= 1'b0;
      wr_data_reg <= 32'h00000000;
      wr_strb_reg <= 4'h0;
      wr_data_full_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BZCG_RESP_OKAY;
      config_reg <= `BZCG_CONFIG_RESET;
      gen_reg <= `BZCG_GEN_RESET;
      mask_reg <= `BZCG_MASK_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_reg <= s_axi_awaddr;
        wr_addr_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
        wr_data_full_reg <= 1'b1;
      end
      if (wr_fire) begin
        wr_addr_full_reg <= 1'b0;
        wr_data_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BZCG_RESP_OKAY;
        case (wr_addr_reg)
          `BZCG_ADDR_CONFIG: begin
            // written value kept below the upper byte, including remapped low-pass codes
            config_reg <= config_merged[23:0];
          end
          `BZCG_ADDR_GEN: begin
            gen_reg <= bzcg_merge(gen_reg, wr_data_reg, wr_strb_reg) & 32'h0000000f;
          end
          `BZCG_ADDR_STATUS: begin
            s_axi_bresp <= `BZCG_RESP_OKAY;
          end
          `BZCG_ADDR_MASK: begin
            mask_reg <= bzcg_merge(mask_reg, wr_data_reg, wr_strb_reg) & 32'h00000001;
          end
          `BZCG_ADDR_DECODE: begin
            s_axi_bresp <= `BZCG_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `BZCG_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // status and compliance edge
  always @(posedge clk) begin
    if (srst) begin
      status_reg <= 32'h00000000;
      fault_seen_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      fault_seen_reg <= watch & compliance_fault;
    end
  end

  // read path: one-cycle answer after address taken
  always @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BZCG_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `BZCG_RESP_OKAY;
      case (s_axi_araddr)
        `BZCG_ADDR_CONFIG: s_axi_rdata <= {8'h00, config_view};
        `BZCG_ADDR_GEN: s_axi_rdata <= gen_reg;
        `BZCG_ADDR_STATUS: s_axi_rdata <= status_reg;
        `BZCG_ADDR_MASK: s_axi_rdata <= mask_reg;
        `BZCG_ADDR_DECODE: s_axi_rdata <= {dec_phase, 7'h00, watch, 1'b0, dec_ua};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BZCG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // registered drive outputs; both drive pins float when off
  always @(posedge clk) begin
    if (srst) begin
      drive_enable <= 1'b0;
      drive_current_ua <= 7'h00;
      drive_out_positive_oe <= 1'b0;
      drive_out_negative_oe <= 1'b0;
      phase_offset_centideg <= 16'h0000;
      effective_lowpass_code <= `BZCG_LPF_DEFAULT;
      monitor_active <= 1'b0;
    end else begin
      drive_enable <= dec_on & gen_reg[`BZCG_GEN_EN_BIT];
      drive_current_ua <= dec_ua;
      drive_out_positive_oe <= dec_on & gen_reg[`BZCG_GEN_EN_BIT];
      drive_out_negative_oe <= dec_on & gen_reg[`BZCG_GEN_EN_BIT];
      phase_offset_centideg <= dec_phase;
      effective_lowpass_code <= lpf_effective;
      monitor_active <= watch;
    end
  end

endmodule

// ---- logic/bzcg_defines.vh ----
`ifndef BZCG_DEFINES_VH
`define BZCG_DEFINES_VH

// register byte addresses on the AXI4-Lite slave
`define BZCG_ADDR_CONFIG 8'h00
`define BZCG_ADDR_GEN 8'h04
`define BZCG_ADDR_STATUS 8'h08
`define BZCG_ADDR_MASK 8'h0c
`define BZCG_ADDR_DECODE 8'h10

// bioimpedance_config field positions
`define BZCG_PHASE_LSB 0
`define BZCG_PHASE_MSB 3
`define BZCG_MAG_LSB 4
`define BZCG_MAG_MSB 6
`define BZCG_MON_BIT 7
`define BZCG_FREQ_LSB 8
`define BZCG_FREQ_MSB 11
`define BZCG_LPF_LSB 12
`define BZCG_LPF_MSB 13

// general register field positions
`define BZCG_GEN_EN_BIT 0
`define BZCG_GEN_RATE_BIT 1
`define BZCG_GEN_MCLK_LSB 2
`define BZCG_GEN_MCLK_MSB 3

// reset values
`define BZCG_CONFIG_RESET 24'h001800
`define BZCG_GEN_RESET 32'h00000000
`define BZCG_MASK_RESET 32'h00000000

// low-pass codes
`define BZCG_LPF_DEFAULT 2'h1
`define BZCG_LPF_HIGHEST 2'h3

// magnitudes in microamps
`define BZCG_MAG_OFF 7'h00
`define BZCG_MAG_8 7'h08
`define BZCG_MAG_16 7'h10
`define BZCG_MAG_32 7'h20
`define BZCG_MAG_48 7'h30
`define BZCG_MAG_64 7'h40
`define BZCG_MAG_96 7'h60

// phase steps in hundredths of a degree
`define BZCG_STEP_FINE 16'd1125
`define BZCG_STEP_MID 16'd2250
`define BZCG_STEP_COARSE 16'd4500

// axi response codes
`define BZCG_RESP_OKAY 2'h0
`define BZCG_RESP_SLVERR 2'h2

`endif

// ---- logic/bzcg_drive_decode.v ----
`timescale 1ns/1ps
`include "bzcg_defines.vh"

module bzcg_drive_decode (
  input wire [2:0] magnitude_code,
  input wire [3:0] frequency_code,
  input wire [3:0] phase_code,
  output reg [6:0] drive_ua,
  output wire drive_on,
  output reg [15:0] phase_centideg
);

  // magnitude code to microamps, reserved code gives off
  always @* begin
    case (magnitude_code)
      3'h1: drive_ua = `BZCG_MAG_8;
      3'h2: drive_ua = `BZCG_MAG_16;
      3'h3: drive_ua = `BZCG_MAG_32;
      3'h4: drive_ua = `BZCG_MAG_48;
      3'h5: drive_ua = `BZCG_MAG_64;
      3'h7: drive_ua = `BZCG_MAG_96;
      default: drive_ua = `BZCG_MAG_OFF;
    endcase
  end

  // generators run for any nonzero defined code
  assign drive_on = (drive_ua != `BZCG_MAG_OFF);

  // phase step depends on modulation frequency
  always @* begin
    if (frequency_code >= 4'h2) begin
      phase_centideg = {12'h000, phase_code} * `BZCG_STEP_FINE;
    end else if (frequency_code == 4'h1) begin
      phase_centideg = {13'h0000, phase_code[3:1]} * `BZCG_STEP_MID;
    end else begin
      phase_centideg = {14'h0000, phase_code[3:2]} * `BZCG_STEP_COARSE;
    end
  end

endmodule

// ---- testbench/bzcg_assertions.sv ----
`timescale 1ns/1ps
// bus handshake and decode relations at the bank ports
module bzcg_assertions (
  input logic clk,
  input logic srst,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic drive_enable,
  input logic [6:0] drive_current_ua,
  input logic drive_out_positive_oe,
  input logic [15:0] phase_offset_centideg,
  input logic monitor_active,
  input logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // answers stand until taken
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // decoded drive and phase stay on the legal grid
  a_mag_legal: assert property (
    drive_current_ua inside {7'h00, 7'h08, 7'h10, 7'h20, 7'h30, 7'h40, 7'h60})
    else $error("bad magnitude");
  a_float_off: assert property (
    drive_current_ua == 7'h00 |-> !drive_out_positive_oe && !drive_enable)
    else $error("pins driven while off");
  a_phase_grid: assert property (
    phase_offset_centideg <= 16'h41eb && phase_offset_centideg % 16'h0465 == 16'h0)
    else $error("phase off grid");
  a_monitor_needs: assert property (monitor_active |-> drive_enable)
    else $error("monitor without drive");
  c_irq: cover property (irq);
  c_mon: cover property (monitor_active);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind bzcg_config_bank bzcg_assertions u_chk (.*);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "bzcg_defines.vh"
module testbench;
  logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, channel_active, compliance_fault, drive_enable, irq;
  logic drive_out_positive_oe, drive_out_negative_oe, monitor_active;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, effective_lowpass_code, resp;
  logic [6:0] drive_current_ua;
  logic [15:0] phase_offset_centideg;
  int bad_count = 0;
  int compares = 0;

  bzcg_config_bank u_dut (.*);

  // 200 MHz clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // one axi transfer, sampled at the falling edge before each take
  task bus(input w, input [7:0] a, input [31:0] d);
    logic ha, hw, hr, done;
    begin
      done = 0;
      @(posedge clk);
      if (w) begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
      end else begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
      end
      while (!done) begin
        @(negedge clk);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        hr = s_axi_arvalid & s_axi_arready;
        done = w ? s_axi_bvalid : s_axi_rvalid;
        resp = w ? s_axi_bresp : s_axi_rresp;
        r = s_axi_rdata;
        @(posedge clk);
        if (ha) s_axi_awvalid <= 0;
        if (hw) s_axi_wvalid <= 0;
        if (hr) s_axi_arvalid <= 0;
      end
      s_axi_bready <= 0;
      s_axi_rready <= 0;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    bus(1, a, d);
  endtask

  task rd(input [7:0] a);
    bus(0, a, 32'h0);
  endtask

  task nap;
    repeat (4) @(negedge clk);
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      compares++;
      if (g !== e) begin
        bad_count++;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // phase step follows the modulation code, low bits ignored
  task t_phase;
    int f[4] = '{0, 1, 2, 15};
    int e[4] = '{13500, 13500, 14625, 14625};
    begin
      for (int i = 0; i < 4; i++) begin
        wr(`BZCG_ADDR_CONFIG, (f[i] << 8) | 32'hd);
        rd(`BZCG_ADDR_DECODE);
        chk(r[31:16], e[i]);
        chk(phase_offset_centideg, e[i]);
      end
    end
  endtask

  // every defined magnitude code
  task t_mag;
    int ua[8] = '{0, 8, 16, 32, 48, 64, 0, 96};
    begin
      wr(`BZCG_ADDR_GEN, 32'h1);
      for (int i = 0; i < 8; i++) begin
        if (i != 6) begin
          wr(`BZCG_ADDR_CONFIG, i << 4);
          rd(`BZCG_ADDR_DECODE);
          chk(r[6:0], ua[i]);
          chk(drive_current_ua, ua[i]);
          chk(drive_out_negative_oe, i != 0);
          chk(drive_enable, i != 0);
        end
      end
    end
  endtask

  // highest cutoff at halved rate, then an unmapped read
  task t_lpf;
    begin
      wr(`BZCG_ADDR_GEN, 32'h3);
      wr(`BZCG_ADDR_CONFIG, 32'h3000);
      rd(`BZCG_ADDR_CONFIG);
      chk(r, 32'h1000);
      chk(resp, 2'h0);
      chk(effective_lowpass_code, 2'h1);
      wr(`BZCG_ADDR_GEN, 32'h1);
      rd(`BZCG_ADDR_CONFIG);
      chk(r, 32'h3000);
      rd(8'h14);
      chk({resp, r}, 34'h200000000);
      wr(8'h14, 32'h0);
      chk(resp, 2'h2);
    end
  endtask

  task fault;
    begin
      @(posedge clk);
      compliance_fault <= 1;
      nap;
      @(posedge clk);
      compliance_fault <= 0;
      nap;
    end
  endtask

  // compliance event raised, masked, cleared, then monitor off
  task t_mon;
    begin
      channel_active <= 1;
      wr(`BZCG_ADDR_MASK, 32'h1);
      wr(`BZCG_ADDR_CONFIG, 32'h0090);
      nap;
      chk(monitor_active, 1'b1);
      fault;
      chk(irq, 1'b1);
      wr(`BZCG_ADDR_MASK, 32'h0);
      chk(irq, 1'b0);
      wr(`BZCG_ADDR_MASK, 32'h1);
      chk(irq, 1'b1);
      wr(`BZCG_ADDR_STATUS, 32'h1);
      chk(irq, 1'b0);
      wr(`BZCG_ADDR_CONFIG, 32'h0010);
      fault;
      chk(monitor_active, 1'b0);
      rd(`BZCG_ADDR_STATUS);
      chk(r, 32'h0);
    end
  endtask

  task end_sim;
    begin
      if (bad_count == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // reset, scenarios, verdict
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, channel_active, compliance_fault} = '0;
    s_axi_wstrb = 4'hf;
    srst = 1;
    repeat (16) @(posedge clk);
    srst <= 0;
    rd(`BZCG_ADDR_CONFIG);
    chk(r, 32'h1800);
    t_phase;
    t_mag;
    t_lpf;
    t_mon;
    end_sim;
  end

  // watchdog
  initial begin
    #40000;
    bad_count++;
    end_sim;
  end
endmodule
